// ===== verilog/mise_defines.svh
`ifndef MISE_DEFINES_SVH
`define MISE_DEFINES_SVH

// register byte offsets
`define MISE_OFS_INSTR 12'h000
`define MISE_OFS_ACC 12'h004
`define MISE_OFS_STATUS 12'h008
`define MISE_OFS_DIR_A 12'h00C
`define MISE_OFS_DIR_B 12'h010
`define MISE_OFS_DIR_C 12'h014
`define MISE_OFS_WDOG 12'h018
`define MISE_OFS_WAKE 12'h01C
// file register window: 0x200 + 4 * index
`define MISE_FILE_HI 3'h1

// instruction word fields
`define MISE_OP_MSB 2
`define MISE_OP_LSB 0
`define MISE_DEST_BIT 3
`define MISE_F_MSB 10
`define MISE_F_LSB 4
`define MISE_K_MSB 23
`define MISE_K_LSB 16

// status bit positions
`define MISE_ST_C 0
`define MISE_ST_HB 1
`define MISE_ST_Z 2
`define MISE_ST_PWRDN 3
`define MISE_ST_EXPIRY 4
`define MISE_ST_SLEEP 5

// direction register operands
`define MISE_DIRSEL_A 7'h05
`define MISE_DIRSEL_B 7'h06
`define MISE_DIRSEL_C 7'h07

// reset values
`define MISE_RST_DIR 8'hFF
`define MISE_RST_ACC 8'h00
`define MISE_RST_WDOG 8'h00

// watchdog prescaler divide, in core clocks
`define MISE_WDOG_PRESCALE 256

`endif

// ===== verilog/mise_pkg.sv
package mise_pkg;

  typedef enum logic [2:0] {
    MISE_OP_SLEEP,
    MISE_OP_SUB,
    MISE_OP_SUBB,
    MISE_OP_SWAP,
    MISE_OP_XORL,
    MISE_OP_XORF,
    MISE_OP_DIR
  } mise_op_e;

  typedef enum logic [1:0] {
    MISE_ST_IDLE,
    MISE_ST_FRD,
    MISE_ST_IRD
  } mise_state_e;

endpackage

// ===== verilog/mise_file_ram.sv
`timescale 1ns/1ps
module mise_file_ram #(
  parameter int AW = 7,
  parameter int DW = 8
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic we,
  input wire logic re,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] mem [0:(1<<AW)-1];
  logic [DW-1:0] rdata_q;

  always_ff @(posedge mclk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata_q <= '0;
    end else if (re) begin
      rdata_q <= mem[addr];
    end
  end

  assign rdata = rdata_q;
endmodule

// ===== verilog/mise_alu.sv
`timescale 1ns/1ps
module mise_alu import mise_pkg::*; (
  input mise_op_e op,
  input wire logic [7:0] acc,
  input wire logic [7:0] fval,
  input wire logic [7:0] k,
  input wire logic carry_in,
  output logic [7:0] result,
  output logic carry_out,
  output logic half_out,
  output logic zero_out
);
  // subtraction as f + ~w + 1, or + carry when the borrow is taken in
  wire logic cin = (op == MISE_OP_SUBB) ? carry_in : 1'b1;
  wire logic [8:0] diff = {1'b0, fval} + {1'b0, ~acc} + {8'h00, cin};
  wire logic [4:0] ndiff = {1'b0, fval[3:0]} + {1'b0, ~acc[3:0]} + {4'h0, cin};
  wire logic is_sub = (op == MISE_OP_SUB) || (op == MISE_OP_SUBB);

  always_comb begin
    unique case (op)
      MISE_OP_SUB, MISE_OP_SUBB: result = diff[7:0];
      MISE_OP_SWAP: result = {fval[3:0], fval[7:4]};
      MISE_OP_XORL: result = acc ^ k;
      MISE_OP_XORF: result = acc ^ fval;
      default: result = acc;
    endcase
  end

  assign carry_out = is_sub ? diff[8] : carry_in;
  assign half_out = ndiff[4];
  assign zero_out = (result == 8'h00);
endmodule

// ===== verilog/mise_core.sv
// The address map and the APB register port were left to the implementer.
`timescale 1ns/1ps
`include "mise_defines.svh"

module mise_core import mise_pkg::*; #(
  parameter int PRESCALE_DIV = `MISE_WDOG_PRESCALE,
  parameter int FILE_AW = 7
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [7:0] port_a_direction,
  output logic [7:0] port_b_direction,
  output logic [7:0] port_c_direction,
  output logic sleep_active
);
  localparam int PW = $clog2(PRESCALE_DIV);

  mise_state_e state_q;
  mise_state_e state_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic pready_q;
  logic pready_d;
  logic slverr_q;
  logic slverr_d;
  logic [7:0] acc_q;
  logic [7:0] acc_d;
  logic c_q;
  logic c_d;
  logic hb_q;
  logic hb_d;
  logic z_q;
  logic z_d;
  logic pwrdn_q;
  logic pwrdn_d;
  logic expiry_q;
  logic expiry_d;
  logic sleep_q;
  logic sleep_d;
  logic [7:0] dira_q;
  logic [7:0] dira_d;
  logic [7:0] dirb_q;
  logic [7:0] dirb_d;
  logic [7:0] dirc_q;
  logic [7:0] dirc_d;
  logic [PW-1:0] pre_q;
  logic [7:0] wdog_q;
  logic wdog_clr;
  logic ram_we;
  logic ram_re;
  logic [FILE_AW-1:0] ram_addr;
  logic [7:0] ram_wdata;
  logic [7:0] ram_rdata;
  logic [7:0] alu_res;
  logic alu_c;
  logic alu_hb;
  logic alu_z;

  // bus decode
  // pready_q masks the answer cycle, so one access is never taken twice
  wire logic access = psel & penable & ~pready_q;
  wire logic sel_instr = (paddr == `MISE_OFS_INSTR);
  wire logic sel_acc = (paddr == `MISE_OFS_ACC);
  wire logic sel_status = (paddr == `MISE_OFS_STATUS);
  wire logic sel_dira = (paddr == `MISE_OFS_DIR_A);
  wire logic sel_dirb = (paddr == `MISE_OFS_DIR_B);
  wire logic sel_dirc = (paddr == `MISE_OFS_DIR_C);
  wire logic sel_wdog = (paddr == `MISE_OFS_WDOG);
  wire logic sel_wake = (paddr == `MISE_OFS_WAKE);
  // file registers sit in a window of their own, one aligned word each
  wire logic sel_file = (paddr[11:9] == `MISE_FILE_HI) && (paddr[1:0] == 2'b00);
  wire logic [FILE_AW-1:0] file_idx = paddr[FILE_AW+1:2];
  wire logic mapped = sel_instr | sel_acc | sel_status | sel_dira | sel_dirb
                    | sel_dirc | sel_wdog | sel_wake | sel_file;

  // instruction fields, held by the master until pready
  wire mise_op_e ins_op = mise_op_e'(pwdata[`MISE_OP_MSB:`MISE_OP_LSB]);
  wire logic ins_dest = pwdata[`MISE_DEST_BIT];
  wire logic [FILE_AW-1:0] ins_f = pwdata[`MISE_F_MSB:`MISE_F_LSB];
  wire logic [7:0] ins_k = pwdata[`MISE_K_MSB:`MISE_K_LSB];
  wire logic op_writes_dest = (ins_op == MISE_OP_SUB) || (ins_op == MISE_OP_SUBB)
                            || (ins_op == MISE_OP_SWAP) || (ins_op == MISE_OP_XORF);

  // only the three arithmetic flags are writable by software
  wire logic [7:0] status_word = {2'b00, sleep_q, expiry_q, pwrdn_q, z_q, hb_q, c_q};

  wire logic [7:0] rd_byte = sel_acc ? acc_q :
                             sel_status ? status_word :
                             sel_dira ? dira_q :
                             sel_dirb ? dirb_q :
                             sel_dirc ? dirc_q :
                             sel_wdog ? wdog_q : 8'h00;

  // one-cycle enable from the prescaler steps the watchdog count
  wire logic pre_wrap = (pre_q == PW'(PRESCALE_DIV - 1));

  // registered read of the file store costs one more wait state
  mise_file_ram #(
    .AW(FILE_AW),
    .DW(8)
  ) u_ram (
    .mclk(mclk),
    .rst(rst),
    .we(ram_we),
    .re(ram_re),
    .addr(ram_addr),
    .wdata(ram_wdata),
    .rdata(ram_rdata)
  );

  // flags of the alu are taken only when an instruction commits
  mise_alu u_alu (
    .op(ins_op),
    .acc(acc_q),
    .fval(ram_rdata),
    .k(ins_k),
    .carry_in(c_q),
    .result(alu_res),
    .carry_out(alu_c),
    .half_out(alu_hb),
    .zero_out(alu_z)
  );

  // next values for the bus answer and the instruction unit
  always_comb begin
    state_d = state_q;
    prdata_d = prdata_q;
    pready_d = 1'b0;
    slverr_d = 1'b0;
    acc_d = acc_q;
    c_d = c_q;
    hb_d = hb_q;
    z_d = z_q;
    pwrdn_d = pwrdn_q;
    expiry_d = expiry_q;
    sleep_d = sleep_q;
    dira_d = dira_q;
    dirb_d = dirb_q;
    dirc_d = dirc_q;
    wdog_clr = 1'b0;
    ram_we = 1'b0;
    ram_re = 1'b0;
    ram_addr = file_idx;
    ram_wdata = pwdata[7:0];
    unique case (state_q)
      MISE_ST_IDLE: begin
        if (access) begin
          if (sel_file && !pwrite) begin
            // file data comes out of a register, so reads take one more cycle
            ram_re = 1'b1;
            state_d = MISE_ST_FRD;
          end else if (sel_instr && pwrite && !sleep_q) begin
            ram_re = 1'b1;
            ram_addr = ins_f;
            state_d = MISE_ST_IRD;
          end else begin
            // an instruction written while halted completes but does nothing
            pready_d = 1'b1;
            slverr_d = ~mapped;
            prdata_d = 32'h0000_0000;
            if (!pwrite) begin
              prdata_d = {24'h00_0000, rd_byte};
            end else begin
              if (sel_file) begin
                ram_we = 1'b1;
              end
              if (sel_acc) begin
                acc_d = pwdata[7:0];
              end
              if (sel_status) begin
                c_d = pwdata[`MISE_ST_C];
                hb_d = pwdata[`MISE_ST_HB];
                z_d = pwdata[`MISE_ST_Z];
              end
              if (sel_wake) begin
                sleep_d = 1'b0;
              end
            end
          end
        end
      end
      MISE_ST_FRD: begin
        // the store's read register was loaded at the access edge
        prdata_d = {24'h00_0000, ram_rdata};
        pready_d = 1'b1;
        state_d = MISE_ST_IDLE;
      end
      MISE_ST_IRD: begin
        pready_d = 1'b1;
        prdata_d = 32'h0000_0000;
        state_d = MISE_ST_IDLE;
        unique case (ins_op)
          MISE_OP_SLEEP: begin
            // once halted, only a write to the wake register or a reset restarts the core
            pwrdn_d = 1'b0;
            expiry_d = 1'b1;
            wdog_clr = 1'b1;
            sleep_d = 1'b1;
          end
          MISE_OP_SUB, MISE_OP_SUBB: begin
            c_d = alu_c;
            hb_d = alu_hb;
            z_d = alu_z;
          end
          MISE_OP_SWAP: begin
            // no flag moves; the result is routed by the destination step below
          end
          MISE_OP_XORL: begin
            acc_d = alu_res;
            z_d = alu_z;
          end
          MISE_OP_XORF: begin
            z_d = alu_z;
          end
          MISE_OP_DIR: begin
            // any other operand leaves every direction register alone
            if (ins_f == `MISE_DIRSEL_A) begin
              dira_d = acc_q;
            end
            if (ins_f == `MISE_DIRSEL_B) begin
              dirb_d = acc_q;
            end
            if (ins_f == `MISE_DIRSEL_C) begin
              dirc_d = acc_q;
            end
          end
          default: begin
            // unused opcode: no effect
          end
        endcase
        // results land at the edge that raises pready, so the next access sees them
        if (op_writes_dest) begin
          if (ins_dest) begin
            ram_we = 1'b1;
            ram_addr = ins_f;
            ram_wdata = alu_res;
          end else begin
            acc_d = alu_res;
          end
        end
      end
      default: begin
        state_d = MISE_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_q <= MISE_ST_IDLE;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      slverr_q <= 1'b0;
    end else begin
      state_q <= state_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      slverr_q <= slverr_d;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      acc_q <= `MISE_RST_ACC;
      c_q <= 1'b0;
      hb_q <= 1'b0;
      z_q <= 1'b0;
    end else begin
      acc_q <= acc_d;
      c_q <= c_d;
      hb_q <= hb_d;
      z_q <= z_d;
    end
  end

  // after power-on both status bits read as one
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pwrdn_q <= 1'b1;
      expiry_q <= 1'b1;
      sleep_q <= 1'b0;
    end else begin
      pwrdn_q <= pwrdn_d;
      expiry_q <= expiry_d;
      sleep_q <= sleep_d;
    end
  end

  // all pins start as inputs
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dira_q <= `MISE_RST_DIR;
      dirb_q <= `MISE_RST_DIR;
      dirc_q <= `MISE_RST_DIR;
    end else begin
      dira_q <= dira_d;
      dirb_q <= dirb_d;
      dirc_q <= dirc_d;
    end
  end

  // watchdog stand-in: it stops with the oscillator, so it cannot wake the core
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pre_q <= '0;
      wdog_q <= `MISE_RST_WDOG;
    end else if (wdog_clr) begin
      pre_q <= '0;
      wdog_q <= `MISE_RST_WDOG;
    end else if (!sleep_q) begin
      // the count wraps at 8 bits and nothing here acts on it
      pre_q <= pre_wrap ? '0 : pre_q + PW'(1);
      if (pre_wrap) begin
        wdog_q <= wdog_q + 8'h01;
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = slverr_q;
  assign port_a_direction = dira_q;
  assign port_b_direction = dirb_q;
  assign port_c_direction = dirc_q;
  assign sleep_active = sleep_q;
endmodule

// ===== verif/mise_core_props.sv
`timescale 1ns/1ps
`include "mise_defines.svh"
module mise_core_props (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] port_a_direction,
  input wire logic [7:0] port_b_direction,
  input wire logic [7:0] port_c_direction,
  input wire logic sleep_active
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // the master still holds the request in the pready cycle, so the word is visible there
  wire logic ins_done = pready && psel && pwrite && paddr == `MISE_OFS_INSTR;
  wire logic rd_done = pready && psel && !pwrite;
  wire logic dir_op = ins_done && pwdata[2:0] == 3'h6;
  property p_sleep_on;
    ins_done && pwdata[2:0] == 3'h0 |-> sleep_active;
  endproperty
  a_sleep_on: assert property (p_sleep_on) else $error("halt missing");
  property p_sleep_cause;
    $rose(sleep_active) |-> ins_done && pwdata[2:0] == 3'h0;
  endproperty
  a_sleep_cause: assert property (p_sleep_cause) else $error("halt uncaused");
  property p_dir_a;
    $changed(port_a_direction) |-> dir_op && pwdata[10:4] == `MISE_DIRSEL_A && !sleep_active;
  endproperty
  a_dir_a: assert property (p_dir_a) else $error("dir a changed");
  property p_dir_b;
    $changed(port_b_direction) |-> dir_op && pwdata[10:4] == `MISE_DIRSEL_B && !sleep_active;
  endproperty
  a_dir_b: assert property (p_dir_b) else $error("dir b changed");
  property p_dir_c;
    $changed(port_c_direction) |-> dir_op && pwdata[10:4] == `MISE_DIRSEL_C && !sleep_active;
  endproperty
  a_dir_c: assert property (p_dir_c) else $error("dir c changed");
  property p_wdog_zero;
    rd_done && paddr == `MISE_OFS_WDOG && sleep_active |-> prdata == 32'h0;
  endproperty
  a_wdog_zero: assert property (p_wdog_zero) else $error("watchdog not zero");
  property p_st_sleep;
    rd_done && paddr == `MISE_OFS_STATUS && sleep_active |-> prdata[5:3] == 3'h6;
  endproperty
  a_st_sleep: assert property (p_st_sleep) else $error("halt status bits");
  property p_ready_bound;
    $rose(penable) && psel |-> ##[1:2] pready;
  endproperty
  a_ready_bound: assert property (p_ready_bound) else $error("no pready");
endmodule
bind mise_core mise_core_props u_props (.mclk, .rst, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .port_a_direction, .port_b_direction,
  .port_c_direction, .sleep_active);

// ===== verif/mcu_instruction_subset_exec_test.sv
`timescale 1ns/1ps
`include "mise_defines.svh"
module mcu_instruction_subset_exec_test import mise_pkg::*; ;
  logic mclk, rst, psel, penable, pwrite, pready, pslverr, errv, sleep_active, d, tofile;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv, r, s;
  logic [31:0] seed = 32'h60;
  logic [7:0] port_a_direction, port_b_direction, port_c_direction, ea, eb, ec;
  logic [6:0] f;
  logic [10:0] e;
  mise_op_e op;
  int err_count, n_tests, i;
  // a short prescale keeps the watchdog moving within the run
  mise_core #(.PRESCALE_DIV(4)) u_dut (.mclk, .rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .port_a_direction, .port_b_direction,
    .port_c_direction, .sleep_active);
  initial begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] ins(input logic [2:0] o, input logic [6:0] fa,
    input logic dd, input logic [7:0] k);
    return {8'h00, k, 5'h00, fa, dd, o};
  endfunction
  // returns {z, half borrow, c, result}; carry clear means a borrow is pending
  function automatic logic [10:0] model(input mise_op_e o, input logic [7:0] a, fv, k,
    input logic [2:0] st);
    logic [8:0] t;
    logic [4:0] h;
    logic b;
    b = o == MISE_OP_SUBB && !st[0];
    t = {1'h0, fv} - a - b;
    h = {1'h0, fv[3:0]} - a[3:0] - b;
    case (o)
      MISE_OP_SUB, MISE_OP_SUBB: return {t[7:0] == 8'h00, !h[4], !t[8], t[7:0]};
      MISE_OP_SWAP: return {st, fv[3:0], fv[7:4]};
      MISE_OP_XORL: return {(a ^ k) == 8'h00, st[1:0], a ^ k};
      default: return {(a ^ fv) == 8'h00, st[1:0], a ^ fv};
    endcase
  endfunction
  task complete_run();
    $display("errors %0d checks %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, x);
    n_tests++;
    if (g !== x) begin
      err_count++;
      $display("BAD %0t got %h want %h", $time, g, x);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] dat);
    int n;
    @(posedge mclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dat;
    @(posedge mclk);
    penable <= 1'h1;
    for (n = 0; n < 20; n++) begin
      @(posedge mclk);
      if (pready === 1'h1) break;
    end
    rdv = prdata;
    errv = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (n == 20) begin
      err_count++;
      complete_run();
    end
  endtask
  initial begin
    repeat (60000) @(posedge mclk);
    err_count++;
    complete_run();
  end
  initial begin
    rst = 1'h1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {ea, eb, ec} = 24'hFFFFFF;
    repeat (2) @(posedge mclk);
    rst <= 1'h0;
    apb(1'h0, `MISE_OFS_STATUS, '0);
    chk(rdv[5:0], 6'h18);
    for (i = 0; i < 40; i++) begin
      r = rnd();
      s = rnd();
      op = mise_op_e'(3'(1 + rnd() % 5));
      f = r[30:24];
      d = r[31];
      if (i < 3) r[23:8] = {r[7:0], r[7:0]};
      tofile = d && op != MISE_OP_XORL;
      e = model(op, r[7:0], r[15:8], r[23:16], s[2:0]);
      apb(1'h1, `MISE_OFS_ACC, r[7:0]);
      apb(1'h1, {`MISE_FILE_HI, f, 2'h0}, r[15:8]);
      apb(1'h1, `MISE_OFS_STATUS, s[2:0]);
      apb(1'h1, `MISE_OFS_INSTR, ins(op, f, d, r[23:16]));
      apb(1'h0, `MISE_OFS_ACC, '0);
      chk(rdv, tofile ? r[7:0] : e[7:0]);
      apb(1'h0, {`MISE_FILE_HI, f, 2'h0}, '0);
      chk(rdv, tofile ? e[7:0] : r[15:8]);
      apb(1'h0, `MISE_OFS_STATUS, '0);
      chk(rdv[2:0], e[10:8]);
    end
    for (i = 4; i < 9; i++) begin
      r = rnd();
      apb(1'h1, `MISE_OFS_ACC, r[7:0]);
      apb(1'h1, `MISE_OFS_INSTR, ins(MISE_OP_DIR, 7'(i), 1'h0, 8'h00));
      if (i == 5) ea = r[7:0];
      if (i == 6) eb = r[7:0];
      if (i == 7) ec = r[7:0];
      chk({port_a_direction, port_b_direction, port_c_direction}, {ea, eb, ec});
    end
    apb(1'h1, `MISE_OFS_STATUS, 32'h5);
    apb(1'h1, `MISE_OFS_INSTR, ins(MISE_OP_SLEEP, 7'h00, 1'h0, 8'h00));
    chk(sleep_active, 1'h1);
    repeat (20) @(posedge mclk);
    apb(1'h0, `MISE_OFS_STATUS, '0);
    chk(rdv[5:0], 6'h35);
    apb(1'h0, `MISE_OFS_WDOG, '0);
    chk(rdv, 32'h0);
    chk({31'h0, errv}, 32'h0);
    apb(1'h1, `MISE_OFS_ACC, 32'h3C);
    apb(1'h1, `MISE_OFS_INSTR, ins(MISE_OP_DIR, 7'h05, 1'h0, 8'h00));
    chk(port_a_direction, ea);
    apb(1'h1, `MISE_OFS_WAKE, '0);
    apb(1'h0, `MISE_OFS_STATUS, '0);
    chk(rdv[5], 1'h0);
    apb(1'h0, 12'h100, '0);
    chk(rdv, 32'h0);
    chk({31'h0, errv}, 32'h1);
    // reset again in mid-run: directions, status and accumulator return to their reset values
    @(posedge mclk);
    rst <= 1'h1;
    repeat (2) @(posedge mclk);
    rst <= 1'h0;
    chk({port_a_direction, port_b_direction, port_c_direction}, 24'hFFFFFF);
    apb(1'h0, `MISE_OFS_STATUS, '0);
    chk(rdv[5:0], 6'h18);
    apb(1'h0, `MISE_OFS_ACC, '0);
    chk(rdv, 32'h0);
    complete_run();
  end
endmodule
